/* File: logic/twbc_controller.sv */
// Two-wire bus controller: registers, master and slave byte engine
//
// Behaviour
// - Set addressed flag on own or general call address; general call flag too.
// - Set lost arbitration flag when another master wins the bus.
// - Bus idle flag cleared by START, set by STOP, read only.
// - Own address holds seven bits, compared one bit offset against received byte.
// - Own address resets to zero.
// - Receive shifts data until acknowledge, then holds SCL low until data read.
// - Transmit starts sending a byte once written, with serial output enabled.
// - Clock select: 00 off, 01 slow, 10 microcontroller, 11 fast source.
// - One bit takes 240 source periods: 96 high, 144 low.
// - Source clock rate sets SCL rate through that fixed ratio.
// - Soft reset bit reinitialises the block while high, never clears itself.
// - Writing pending bit one clears all flags but bus idle; zero does nothing.
// - Control write and status read share one address; resets 0x00 and 0x81.
// - Registers reached only over microcontroller bus at consecutive addresses.
// - A START condition on the bus raises a wake-up to the microcontroller.
// - Pending goes low after nine clocks; high on data write or read.
// - Start/stop bits: start, stop, stop then start, or nothing.
// - Acknowledge bit drives ACK on ninth clock; cleared sends not-acknowledge.
// - Interrupt enable drives interrupt low while pending is low.
`timescale 1ns/10ps
module twbc_controller (
    input  logic                core_clk_i,
    input  logic                reset_i,
    input  twbc_pkg::twbc_req_s req_i,
    output logic [7:0]          rdata_o,
    input  logic                tick_32k_i,
    input  logic                tick_mcu_i,
    input  logic                tick_24m_i,
    input  logic                scl_in_i,
    output logic                scl_out_o,
    output logic                scl_oe_o,
    input  logic                sda_in_i,
    output logic                sda_out_o,
    output logic                sda_oe_o,
    output logic                controller_irq_n_o,
    output logic                wake_o
);
    import twbc_pkg::*;

    twbc_state_s s_r;
    twbc_state_s s_nxt;
    logic        tick;
    logic        act;
    logic        run;
    logic        scl_h;
    logic        scl_p;
    logic        sda_h;
    logic        sda_p;
    logic        start_det;
    logic        stop_det;
    logic        rise;
    logic        fall;
    logic        gcall;
    logic        match;
    logic        drv;
    logic        hi_done;
    logic        lo_done;
    logic [7:0]  stat;
    logic [7:0]  wd;

    function automatic twbc_state_s init_state();
        twbc_state_s v;
        v          = '0;
        v.scl_sy   = '1;
        v.sda_sy   = '1;
        v.pin      = STATUS_RST[S_PIN];
        v.bus_idle_flag      = STATUS_RST[S_NBB];
        v.serial_output_enable      = CTRL_RST[C_ESO];
        v.irq_enable      = CTRL_RST[C_ENI];
        v.ack      = CTRL_RST[C_ACK];
        v.own      = OWN_RST[OWN_MSB:0];
        v.shift    = DATA_RST;
        v.soft_rst = CLK_RST[K_RST];
        v.sel      = CLK_RST[SEL_MSB:SEL_LSB];
        v.irq_n    = 1'b1;
        v.mst      = M_IDLE;
        return v;
    endfunction

    // Soft reset keeps the clock register, synchronisers and read data
    function automatic twbc_state_s reinit(twbc_state_s k);
        twbc_state_s v;
        v          = init_state();
        v.scl_sy   = k.scl_sy;
        v.sda_sy   = k.sda_sy;
        v.soft_rst = k.soft_rst;
        v.sel      = k.sel;
        v.rdata    = k.rdata;
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        s_nxt        = s_r;
        wd           = req_i.wdata;
        s_nxt.scl_sy = {s_r.scl_sy[1:0], scl_in_i};
        s_nxt.sda_sy = {s_r.sda_sy[1:0], sda_in_i};
        s_nxt.wake   = 1'b0;
        scl_h        = s_r.scl_sy[1];
        scl_p        = s_r.scl_sy[2];
        sda_h        = s_r.sda_sy[1];
        sda_p        = s_r.sda_sy[2];
        unique case (s_r.sel)
            SEL_OFF:  tick = 1'b0;
            SEL_SLOW: tick = tick_32k_i;
            SEL_MCU:  tick = tick_mcu_i;
            SEL_FAST: tick = tick_24m_i;
        endcase
        act       = (s_r.sel != SEL_OFF) && !s_r.soft_rst;
        run       = act && s_r.serial_output_enable;
        start_det = scl_h && scl_p && sda_p && !sda_h;
        stop_det  = scl_h && scl_p && !sda_p && sda_h;
        rise      = scl_h && !scl_p;
        fall      = !scl_h && scl_p;
        gcall     = s_r.shift[DATA_MSB:1] == GENERAL_CALL;
        match     = gcall || (s_r.shift[DATA_MSB:1] == s_r.own);
        drv       = (s_r.bcnt == ACK_SLOT) ? (!s_r.trm && s_r.ack) : (s_r.trm && !s_r.shift[DATA_MSB]);
        hi_done   = tick && scl_h && (s_r.cnt == SCL_HIGH_PERIODS - CNT_ONE);
        lo_done   = tick && (s_r.cnt == SCL_LOW_PERIODS - CNT_ONE);
        stat        = '0;
        stat[S_PIN] = s_r.pin;
        stat[S_STS] = s_r.sts;
        stat[S_BER] = s_r.bus_error;
        stat[S_LRB] = s_r.last_received_bit;
        stat[S_AAS] = s_r.addressed_as_slave;
        stat[S_LAB] = s_r.lost_arbitration;
        stat[S_NBB] = s_r.bus_idle_flag;

        ////////////////////////////////////////////////////////////////////////
        // Register reads, one cycle latency
        if (req_i.rd) begin
            case (req_i.addr)
                ADDR_CTRL_STAT: begin
                    s_nxt.rdata = s_r.serial_output_enable ? stat : {s_r.pin, 3'h0, s_r.irq_enable, s_r.begin_request, s_r.end_request, s_r.ack};
                end
                ADDR_OWN: begin
                    s_nxt.rdata = {1'b0, s_r.own};
                end
                ADDR_DATA: begin
                    s_nxt.rdata = s_r.shift;
                    if (!s_r.trm && !s_r.pin) begin
                        s_nxt.pin = 1'b1;
                    end
                end
                ADDR_CLK: begin
                    s_nxt.rdata = {s_r.soft_rst, 5'h00, s_r.sel};
                end
                default: begin
                    s_nxt.rdata = 8'h00;
                end
            endcase
        end

        // Register writes
        if (req_i.wr) begin
            case (req_i.addr)
                ADDR_CTRL_STAT: begin
                    s_nxt.serial_output_enable = wd[C_ESO];
                    s_nxt.irq_enable = wd[C_ENI];
                    s_nxt.begin_request = wd[C_STA];
                    s_nxt.end_request = wd[C_STO];
                    s_nxt.ack = wd[C_ACK];
                    if (wd[C_PIN]) begin
                        s_nxt.pin = 1'b1;
                        s_nxt.sts = 1'b0;
                        s_nxt.bus_error = 1'b0;
                        s_nxt.last_received_bit = 1'b0;
                        s_nxt.addressed_as_slave = 1'b0;
                        s_nxt.lost_arbitration = 1'b0;
                    end
                    s_nxt.sta_pend = wd[C_STA] && (s_r.master || !wd[C_STO]);
                    s_nxt.sto_pend = wd[C_STO] && s_r.master;
                end
                ADDR_OWN: begin
                    s_nxt.own = wd[OWN_MSB:0];
                end
                ADDR_DATA: begin
                    s_nxt.shift = wd;
                    if (s_r.trm && !s_r.pin) begin
                        s_nxt.pin = 1'b1;
                        if (s_r.hold) begin
                            s_nxt.sda_low = !wd[DATA_MSB];
                        end
                    end
                end
                ADDR_CLK: begin
                    s_nxt.soft_rst = wd[K_RST];
                    s_nxt.sel      = wd[SEL_MSB:SEL_LSB];
                end
                default: begin
                end
            endcase
        end

        ////////////////////////////////////////////////////////////////////////
        // Bus condition tracking
        if (act) begin
            if (start_det) begin
                s_nxt.bus_idle_flag  = 1'b0;
                s_nxt.wake = 1'b1;
            end
            if (stop_det) begin
                s_nxt.bus_idle_flag = 1'b1;
            end
        end

        // Slave engine follows SCL edges from the bus
        if (run && !s_r.master) begin
            if (start_det) begin
                s_nxt.bcnt    = '0;
                s_nxt.addr_ph = 1'b1;
                s_nxt.slv_act = 1'b1;
                s_nxt.trm     = 1'b0;
                s_nxt.sda_low = 1'b0;
            end else if (stop_det) begin
                s_nxt.slv_act = 1'b0;
                s_nxt.sda_low = 1'b0;
                if (s_r.addressed_as_slave && !s_r.trm) begin
                    s_nxt.sts = 1'b1;
                    s_nxt.pin = 1'b0;
                end
            end else if (s_r.slv_act && rise) begin
                if (s_r.bcnt == ACK_SLOT) begin
                    if (!s_r.addr_ph) begin
                        s_nxt.last_received_bit = sda_h;
                    end
                end else begin
                    s_nxt.shift = {s_r.shift[DATA_MSB-1:0], sda_h};
                end
                s_nxt.bcnt = s_r.bcnt + BIT_ONE;
            end else if (s_r.slv_act && fall) begin
                if (s_r.bcnt == ACK_SLOT) begin
                    if (!s_r.addr_ph) begin
                        s_nxt.sda_low = !s_r.trm && s_r.ack;
                    end else if (match) begin
                        s_nxt.addressed_as_slave     = 1'b1;
                        s_nxt.last_received_bit     = gcall;
                        s_nxt.trm     = s_r.shift[RW_BIT];
                        s_nxt.sda_low = s_r.ack;
                    end else begin
                        s_nxt.slv_act = 1'b0;
                    end
                end else if (s_r.bcnt == BYTE_DONE) begin
                    s_nxt.bcnt    = '0;
                    s_nxt.addr_ph = 1'b0;
                    s_nxt.sda_low = 1'b0;
                    if (s_r.trm && s_r.last_received_bit && !s_r.addr_ph) begin
                        s_nxt.slv_act = 1'b0;
                    end else begin
                        s_nxt.pin     = 1'b0;
                        s_nxt.hold    = 1'b1;
                        s_nxt.scl_low = 1'b1;
                    end
                end else begin
                    s_nxt.sda_low = s_r.trm && !s_r.shift[DATA_MSB];
                end
            end
            if (s_r.hold && s_r.pin) begin
                s_nxt.hold    = 1'b0;
                s_nxt.scl_low = 1'b0;
            end
        end

        ////////////////////////////////////////////////////////////////////////
        // Master engine; phase counter clears to zero while SCL is stretched
        if (run) begin
            if (tick) begin
                s_nxt.cnt = (scl_h || s_r.scl_low) ? s_r.cnt + CNT_ONE : '0;
            end
            if (s_r.master && (start_det || stop_det) && (s_r.mst == M_BIT_LOW || s_r.mst == M_BIT_HIGH)) begin
                s_nxt.bus_error     = 1'b1;
                s_nxt.pin     = 1'b0;
                s_nxt.master  = 1'b0;
                s_nxt.scl_low = 1'b0;
                s_nxt.sda_low = 1'b0;
                s_nxt.mst     = M_IDLE;
            end else begin
                unique case (s_r.mst)
                    M_IDLE: begin
                        if (s_r.sta_pend && s_r.bus_idle_flag && !s_r.hold) begin
                            s_nxt.master   = 1'b1;
                            s_nxt.trm      = 1'b1;
                            s_nxt.addr_ph  = 1'b1;
                            s_nxt.sta_pend = 1'b0;
                            s_nxt.slv_act  = 1'b0;
                            s_nxt.sda_low  = 1'b1;
                            s_nxt.cnt      = '0;
                            s_nxt.mst      = M_START;
                        end
                    end
                    M_START: begin
                        if (hi_done) begin
                            s_nxt.scl_low = 1'b1;
                            s_nxt.cnt     = '0;
                            s_nxt.bcnt    = '0;
                            s_nxt.mst     = M_BIT_LOW;
                        end
                    end
                    M_BIT_LOW: begin
                        s_nxt.sda_low = drv;
                        if (lo_done) begin
                            s_nxt.scl_low = 1'b0;
                            s_nxt.cnt     = '0;
                            s_nxt.mst     = M_BIT_HIGH;
                        end
                    end
                    M_BIT_HIGH: begin
                        if (tick && scl_h && s_r.cnt == '0) begin
                            if (s_r.bcnt == ACK_SLOT) begin
                                s_nxt.last_received_bit = sda_h;
                            end else begin
                                s_nxt.shift = {s_r.shift[DATA_MSB-1:0], sda_h};
                            end
                        end
                        if (tick && scl_h && s_r.cnt == '0 && s_r.bcnt != ACK_SLOT
                            && s_r.trm && !s_r.sda_low && !sda_h) begin
                            s_nxt.lost_arbitration     = 1'b1;
                            s_nxt.pin     = 1'b0;
                            s_nxt.master  = 1'b0;
                            s_nxt.slv_act = 1'b1;
                            s_nxt.bcnt    = s_r.bcnt + BIT_ONE;
                            s_nxt.mst     = M_IDLE;
                        end else if (hi_done) begin
                            s_nxt.scl_low = 1'b1;
                            s_nxt.cnt     = '0;
                            if (s_r.bcnt == ACK_SLOT) begin
                                s_nxt.pin     = 1'b0;
                                s_nxt.bcnt    = '0;
                                s_nxt.sda_low = 1'b0;
                                s_nxt.mst     = M_HOLD;
                                if (s_r.addr_ph) begin
                                    s_nxt.trm     = !s_r.shift[RW_BIT];
                                    s_nxt.addr_ph = 1'b0;
                                end
                            end else begin
                                s_nxt.bcnt = s_r.bcnt + BIT_ONE;
                                s_nxt.mst  = M_BIT_LOW;
                            end
                        end
                    end
                    M_HOLD: begin
                        if (s_r.sto_pend) begin
                            s_nxt.sto_pend = 1'b0;
                            s_nxt.sda_low  = 1'b1;
                            s_nxt.cnt      = '0;
                            s_nxt.mst      = M_STOP_LOW;
                        end else if (s_r.pin) begin
                            s_nxt.cnt = '0;
                            if (s_r.sta_pend) begin
                                s_nxt.sta_pend = 1'b0;
                                s_nxt.addr_ph  = 1'b1;
                                s_nxt.trm      = 1'b1;
                                s_nxt.mst      = M_RS_LOW;
                            end else begin
                                s_nxt.mst = M_BIT_LOW;
                            end
                        end
                    end
                    M_RS_LOW: begin
                        if (lo_done) begin
                            s_nxt.scl_low = 1'b0;
                            s_nxt.cnt     = '0;
                            s_nxt.mst     = M_RS_HIGH;
                        end
                    end
                    M_RS_HIGH: begin
                        if (hi_done) begin
                            s_nxt.sda_low = 1'b1;
                            s_nxt.cnt     = '0;
                            s_nxt.mst     = M_START;
                        end
                    end
                    M_STOP_LOW: begin
                        if (lo_done) begin
                            s_nxt.scl_low = 1'b0;
                            s_nxt.cnt     = '0;
                            s_nxt.mst     = M_STOP_HIGH;
                        end
                    end
                    M_STOP_HIGH: begin
                        if (hi_done) begin
                            s_nxt.sda_low = 1'b0;
                            s_nxt.master  = 1'b0;
                            s_nxt.trm     = 1'b0;
                            s_nxt.mst     = M_IDLE;
                        end
                    end
                endcase
            end
        end

        s_nxt.irq_n = !(s_nxt.irq_enable && !s_nxt.pin);
        if (s_r.soft_rst) begin
            s_nxt = reinit(s_nxt);
        end
        if (reset_i) begin
            s_nxt = init_state();
        end
    end

    always_ff @(posedge core_clk_i) begin
        s_r <= s_nxt;
    end

    assign rdata_o            = s_r.rdata;
    assign scl_out_o          = 1'b0;
    assign scl_oe_o           = s_r.scl_low;
    assign sda_out_o          = 1'b0;
    assign sda_oe_o           = s_r.sda_low;
    assign controller_irq_n_o = s_r.irq_n;
    assign wake_o             = s_r.wake;
endmodule

/* File: logic/twbc_pkg.sv */
// Package for the two-wire bus controller: register map, fields, types
package twbc_pkg;
    // Register addresses on the microcontroller data space
    localparam logic [15:0] ADDR_CTRL_STAT = 16'h7f31;
    localparam logic [15:0] ADDR_OWN       = 16'h7f32;
    localparam logic [15:0] ADDR_DATA      = 16'h7f33;
    localparam logic [15:0] ADDR_CLK       = 16'h7f34;
    // Reset values and general call address
    localparam logic [7:0]  STATUS_RST     = 8'h81;
    localparam logic [7:0]  CTRL_RST       = 8'h00;
    localparam logic [7:0]  OWN_RST        = 8'h00;
    localparam logic [7:0]  DATA_RST       = 8'h00;
    localparam logic [7:0]  CLK_RST        = 8'h00;
    localparam logic [6:0]  GENERAL_CALL   = 7'h00;
    // Control write fields
    localparam int C_PIN = 7;
    localparam int C_ESO = 6;
    localparam int C_ENI = 3;
    localparam int C_STA = 2;
    localparam int C_STO = 1;
    localparam int C_ACK = 0;
    // Status read fields
    localparam int S_PIN = 7;
    localparam int S_STS = 5;
    localparam int S_BER = 4;
    localparam int S_LRB = 3;
    localparam int S_AAS = 2;
    localparam int S_LAB = 1;
    localparam int S_NBB = 0;
    // Own address, data and clock register fields
    localparam int OWN_MSB  = 6;
    localparam int DATA_MSB = 7;
    localparam int RW_BIT   = 0;
    localparam int K_RST    = 7;
    localparam int SEL_MSB  = 1;
    localparam int SEL_LSB  = 0;
    localparam logic [1:0] SEL_OFF  = 2'h0;
    localparam logic [1:0] SEL_SLOW = 2'h1;
    localparam logic [1:0] SEL_MCU  = 2'h2;
    localparam logic [1:0] SEL_FAST = 2'h3;
    // SCL phases in source clock periods: high 96, low 144
    localparam logic [7:0] SCL_HIGH_PERIODS = 8'h60;
    localparam logic [7:0] SCL_LOW_PERIODS  = 8'h90;
    localparam logic [7:0] CNT_ONE          = 8'h01;
    localparam logic [3:0] ACK_SLOT         = 4'h8;
    localparam logic [3:0] BYTE_DONE        = 4'h9;
    localparam logic [3:0] BIT_ONE          = 4'h1;

    typedef enum logic [3:0] {
        M_IDLE, M_START, M_BIT_LOW, M_BIT_HIGH, M_HOLD,
        M_RS_LOW, M_RS_HIGH, M_STOP_LOW, M_STOP_HIGH
    } twbc_mst_e;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } twbc_req_s;

    typedef struct packed {
        logic [2:0] scl_sy;
        logic [2:0] sda_sy;
        logic       serial_output_enable, irq_enable, begin_request, end_request, ack;
        logic       pin, sts, bus_error, last_received_bit, addressed_as_slave, lost_arbitration, bus_idle_flag;
        logic [6:0] own;
        logic [7:0] shift;
        logic       soft_rst;
        logic [1:0] sel;
        twbc_mst_e  mst;
        logic       master, trm, addr_ph, sta_pend, sto_pend;
        logic [3:0] bcnt;
        logic [7:0] cnt;
        logic       slv_act, hold, scl_low, sda_low;
        logic [7:0] rdata;
        logic       irq_n, wake;
    } twbc_state_s;
endpackage

/* File: verification/twbc_bus_partner.sv */
// Bus partner model: slave that acks only the first byte of each frame
`timescale 1ns/10ps
module twbc_bus_partner (
    input  logic       scl_i,
    input  logic       sda_i,
    output logic       sda_oe_o,
    output logic [7:0] byte_o
);
    int         nbit = 0;
    int         nbyte = 0;
    logic [7:0] sh = 8'h00;
    initial sda_oe_o = 1'b0;
    initial byte_o = 8'h00;
    ////////////////////////////////////////////////////////////
    always @(negedge sda_i) if (scl_i) begin
        nbit = -1;
        nbyte = 0;
    end
    always @(posedge scl_i) if (nbit < 8) sh = {sh[6:0], sda_i};
    always @(negedge scl_i) begin
        nbit = nbit + 1;
        if (nbit == 8) begin
            byte_o = sh;
            sda_oe_o = (nbyte == 0);
        end else if (nbit == 9) begin
            sda_oe_o = 1'b0;
            nbit = 0;
            nbyte = nbyte + 1;
        end
    end
endmodule

/* File: verification/twbc_controller_chk.sv */
// Port checker for the two-wire bus controller
`timescale 1ns/10ps
module twbc_controller_chk (
    input logic                core_clk_i,
    input logic                reset_i,
    input twbc_pkg::twbc_req_s req_i,
    input logic [7:0]          rdata_o,
    input logic                scl_out_o,
    input logic                scl_oe_o,
    input logic                sda_out_o,
    input logic                sda_oe_o,
    input logic                controller_irq_n_o,
    input logic                wake_o
);
    import twbc_pkg::*;
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (reset_i);
    logic [8:0] low_cnt_r;
    always_ff @(posedge core_clk_i) begin
        if (reset_i || !scl_oe_o) low_cnt_r <= 9'h000;
        else if (low_cnt_r != 9'h1ff) low_cnt_r <= low_cnt_r + 9'h001;
    end
    ////////////////////////////////////////////////////////////
    reset_out_a: assert property (disable iff (1'b0) reset_i |=> controller_irq_n_o && !scl_oe_o
        && !sda_oe_o && !wake_o && rdata_o == 8'h00) else $error("outputs not at reset values");
    unmapped_rd_a: assert property (req_i.rd && (req_i.addr < ADDR_CTRL_STAT || req_i.addr > ADDR_CLK)
        |=> rdata_o == 8'h00) else $error("unmapped read not zero");
    rd_hold_a: assert property (!req_i.rd |=> $stable(rdata_o))
        else $error("read data moved without a read");
    own_rsv_a: assert property (req_i.rd && req_i.addr == ADDR_OWN |=> !rdata_o[7])
        else $error("own address bit 7 not zero");
    clk_rsv_a: assert property (req_i.rd && req_i.addr == ADDR_CLK |=> rdata_o[6:2] == 5'h00)
        else $error("clock reserved bits not zero");
    scl_low_a: assert property ($fell(scl_oe_o) |-> low_cnt_r >= 9'h090)
        else $error("scl low phase too short");
    wake_pulse_a: assert property (wake_o |=> !wake_o)
        else $error("wake longer than one cycle");
    open_drain_a: assert property (!scl_out_o && !sda_out_o)
        else $error("pin driven high");
    irq_pin_a: assert property (req_i.rd && req_i.addr == ADDR_CTRL_STAT && !controller_irq_n_o
        |=> !rdata_o[S_PIN]) else $error("interrupt low while pending bit reads high");
    start_cov: cover property (wake_o);
    irq_cov: cover property ($fell(controller_irq_n_o));
    scl_cov: cover property ($rose(scl_oe_o));
endmodule
bind twbc_controller twbc_controller_chk i_twbc_controller_chk (.core_clk_i(core_clk_i), .reset_i(reset_i),
    .req_i(req_i), .rdata_o(rdata_o), .scl_out_o(scl_out_o), .scl_oe_o(scl_oe_o), .sda_out_o(sda_out_o),
    .sda_oe_o(sda_oe_o), .controller_irq_n_o(controller_irq_n_o), .wake_o(wake_o));

/* File: verification/tb_twbc_controller.sv */
// Testbench for the two-wire bus controller
`timescale 1ns/10ps
module tb_twbc_controller;
    import twbc_pkg::*;
    logic       core_clk_i, reset_i, scl_o, scl_oe, sda_o, sda_oe, p_oe, irq_n, scl_w, sda_w, wake, tick_h;
    twbc_req_s  req;
    logic [7:0] rdata, p_byte;
    int         n_fail, cmp_count;
    int         n_wake, lo_len, lo_last;
    assign scl_w = scl_oe ? scl_o : 1'b1;
    assign sda_w = (sda_oe ? sda_o : 1'b1) & !p_oe;
    twbc_controller i_twbc_controller (.core_clk_i(core_clk_i), .reset_i(reset_i), .req_i(req), .rdata_o(rdata),
        .tick_32k_i(1'b0), .tick_mcu_i(tick_h), .tick_24m_i(1'b1), .scl_in_i(scl_w), .scl_out_o(scl_o),
        .scl_oe_o(scl_oe), .sda_in_i(sda_w), .sda_out_o(sda_o), .sda_oe_o(sda_oe),
        .controller_irq_n_o(irq_n), .wake_o(wake));
    twbc_bus_partner i_twbc_bus_partner (.scl_i(scl_w), .sda_i(sda_w), .sda_oe_o(p_oe), .byte_o(p_byte));
    // Microcontroller source at half the core rate
    always @(posedge core_clk_i) #1 tick_h = (tick_h !== 1'b1);
    // Wake pulses and length of the last SCL low phase driven
    always @(posedge core_clk_i) begin
        if (wake === 1'b1) n_wake++;
        if (scl_oe === 1'b1) lo_len++;
        else begin
            if (lo_len != 0) lo_last = lo_len;
            lo_len = 0;
        end
    end
    ////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d);
        @(posedge core_clk_i) #1;
        req = '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge core_clk_i) #1;
        req = '0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        acc(1'b0, a, 8'h00);
        chk(rdata, exp);
    endtask
    task automatic wait_st(input int b, input logic v);
        int k;
        for (k = 0; k < 4000; k++) begin
            acc(1'b0, ADDR_CTRL_STAT, 8'h00);
            if (rdata[b] === v) break;
        end
        chk({7'h00, rdata[b]}, {7'h00, v});
    endtask
    task automatic conclude;
        if (n_fail == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        core_clk_i = 1'b0;
        forever #25 core_clk_i = !core_clk_i;
    end
    initial begin
        repeat (40000) @(posedge core_clk_i);
        n_fail++;
        conclude();
    end
    initial begin
        req = '0;
        reset_i = 1'b1;
        n_fail = 0;
        cmp_count = 0;
        repeat (3) @(posedge core_clk_i);
        #1 reset_i = 1'b0;
        rd(ADDR_CTRL_STAT, 8'h80);
        rd(ADDR_OWN, OWN_RST);
        rd(ADDR_DATA, DATA_RST);
        rd(ADDR_CLK, CLK_RST);
        rd(16'h7f35, 8'h00);
        acc(1'b1, ADDR_OWN, 8'hff);
        rd(ADDR_OWN, 8'h7f);
        acc(1'b1, ADDR_CLK, 8'h7f);
        rd(ADDR_CLK, 8'h03);
        acc(1'b1, ADDR_CTRL_STAT, 8'hc0);
        rd(ADDR_CTRL_STAT, STATUS_RST);
        // Master write: first byte acked, second refused
        acc(1'b1, ADDR_DATA, 8'ha4);
        acc(1'b1, ADDR_CTRL_STAT, 8'hcd);
        wait_st(S_PIN, 1'b0);
        chk({7'h00, irq_n}, 8'h00);
        rd(ADDR_CTRL_STAT, 8'h00);
        chk(p_byte, 8'ha4);
        chk(n_wake[7:0], 8'h01);
        chk(lo_last[7:0], SCL_LOW_PERIODS);
        acc(1'b1, ADDR_DATA, 8'h3c);
        rd(ADDR_CTRL_STAT, 8'h80);
        chk({7'h00, irq_n}, 8'h01);
        wait_st(S_PIN, 1'b0);
        rd(ADDR_CTRL_STAT, 8'h08);
        chk(p_byte, 8'h3c);
        acc(1'b1, ADDR_CTRL_STAT, 8'hcb);
        rd(ADDR_CTRL_STAT, 8'h80);
        wait_st(S_NBB, 1'b1);
        rd(ADDR_CTRL_STAT, 8'h81);
        // Clock off: a start request must not reach the wire
        acc(1'b1, ADDR_CLK, 8'h00);
        acc(1'b1, ADDR_CTRL_STAT, 8'hc5);
        repeat (600) @(posedge core_clk_i);
        chk({6'h00, scl_oe, sda_oe}, 8'h00);
        rd(ADDR_CTRL_STAT, 8'h81);
        chk(n_wake[7:0], 8'h01);
        // Soft reset held, then left
        acc(1'b1, ADDR_CLK, 8'h80);
        rd(ADDR_OWN, 8'h00);
        rd(ADDR_CTRL_STAT, 8'h80);
        rd(ADDR_CLK, 8'h80);
        acc(1'b1, ADDR_CLK, 8'h00);
        rd(ADDR_CLK, 8'h00);
        // Half-rate source: low phase doubles in core cycles
        acc(1'b1, ADDR_CLK, {6'h00, SEL_MCU});
        acc(1'b1, ADDR_DATA, 8'h5a);
        acc(1'b1, ADDR_CTRL_STAT, 8'hc5);
        wait_st(S_PIN, 1'b0);
        chk(lo_last[8:1], SCL_LOW_PERIODS);
        conclude();
    end
endmodule
